/* File: rtl/self_test_pkg.sv */
// Shared constants and types for the power-up self-test sequencer and fault reporter.
// Functional notes
// - Run self-test at power-up and on zero key in first set-up page.
// - A processor reset sequence runs the full power-up sequence with tests.
// - Test enhanced video memory only if fitted; always settings store and keyboard.
// - All tests pass: cursor goes home and all four fault LEDs turn off.
// - A fatal fault stops all operation at once; screen content may be garbage.
// - After a fatal fault a code may show on the four fault LEDs.
// - Nonfatal fault: keep running, force local mode, write one code character home.
// - Track five separate nonfatal fault classes.
// - Code characters 1,2,4,8,@ per class; combined faults add the weights.
// - Loopback and modem-line tests skip power-up; processor requests each one.
// - Local mode: no host traffic either way; keystrokes echo to the screen.
package self_test_pkg;

	// APB register byte offsets
	localparam logic [7:0] OFS_CTRL       = 8'h00;
	localparam logic [7:0] OFS_STATUS     = 8'h04;
	localparam logic [7:0] OFS_INT_STATUS = 8'h08;
	localparam logic [7:0] OFS_INT_MASK   = 8'h0c;
	localparam logic [7:0] OFS_CODE       = 8'h10;

	// Control register fields
	localparam int CTRL_EVM_FITTED  = 0;
	localparam int CTRL_LOCAL_SEL   = 1;
	localparam int CTRL_START       = 2;
	localparam int CTRL_RESUME_LINE = 3;
	localparam int CTRL_LED_LSB     = 4;

	// Status register fields
	localparam int STAT_BUSY        = 0;
	localparam int STAT_HALTED      = 1;
	localparam int STAT_LOCAL       = 2;
	localparam int STAT_MASK_LSB    = 8;
	localparam int STAT_FATAL_LSB   = 16;

	// Interrupt status bits
	localparam int INT_PASS         = 0;
	localparam int INT_NONFATAL     = 1;
	localparam int INT_FATAL        = 2;

	// Reset values
	localparam logic       RST_EVM_FITTED = 1'b0;
	localparam logic [2:0] RST_INT_MASK   = 3'h0;
	localparam logic [3:0] RST_LED        = 4'h0;

	// Base of the displayed code character
	localparam logic [7:0] CODE_BASE      = 8'h30;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_ISSUE  = 3'b001,
		ST_WAIT   = 3'b010,
		ST_REPORT = 3'b011,
		ST_HALT   = 3'b100
	} state_t;

	// Test selector; the value is also the fault-mask bit index
	typedef enum logic [2:0] {
		TEST_EVM   = 3'b000,
		TEST_STORE = 3'b001,
		TEST_KBD   = 3'b010,
		TEST_LOOP  = 3'b011,
		TEST_MODEM = 3'b100
	} test_t;

endpackage

/* File: rtl/fault_code_former.sv */
// Registered fault code character former.
`timescale 1ns/1ps
module fault_code_former #(
	parameter int MASK_W = 5
) (
	input  wire logic              clk_in,
	input  wire logic              reset_in,
	input  wire logic              load_in,
	input  wire logic [MASK_W-1:0] mask_in,
	output logic      [7:0]        char_out
);

	// The code table only covers five fault classes
	if (MASK_W != 5) begin : g_mask_check
		$error("fault_code_former needs a five-bit mask");
	end

	logic [7:0] char_reg;

	// Weighted sum is simply the base plus the mask
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			char_reg <= self_test_pkg::CODE_BASE;
		end else if (load_in) begin
			char_reg <= self_test_pkg::CODE_BASE + {3'h0, mask_in};
		end
	end

	assign char_out = char_reg;

endmodule

/* File: rtl/powerup_self_test_reporter.sv */
// Power-up self-test sequencer, fault reporter and line/local data gate.
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
module powerup_self_test_reporter #(
	parameter int ADDR_W = 8
) (
	input  wire logic              clk_in,
	input  wire logic              reset_in,
	// APB slave
	input  wire logic              psel_in,
	input  wire logic              penable_in,
	input  wire logic              pwrite_in,
	input  wire logic [ADDR_W-1:0] paddr_in,
	input  wire logic [31:0]       pwdata_in,
	output logic                   pready_out,
	output logic      [31:0]       prdata_out,
	output logic                   pslverr_out,
	output logic                   irq_out,
	// Restart events and single-test requests
	input  wire logic              setup_page_a_in,
	input  wire logic              key_zero_in,
	input  wire logic              proc_reset_in,
	input  wire logic              proc_loopback_req_in,
	input  wire logic              proc_modem_req_in,
	// Test engine handshake
	output logic                   test_req_out,
	output logic      [2:0]        test_sel_out,
	input  wire logic              test_done_in,
	input  wire logic              test_fault_in,
	input  wire logic              test_fatal_in,
	input  wire logic [3:0]        test_fatal_code_in,
	// Screen and indicators
	output logic                   cursor_home_out,
	output logic                   code_write_out,
	output logic      [7:0]        code_char_out,
	output logic      [3:0]        fault_leds_out,
	output logic                   halted_out,
	output logic                   local_mode_out,
	// Character paths
	input  wire logic              key_valid_in,
	input  wire logic [7:0]        key_data_in,
	input  wire logic              host_rx_valid_in,
	input  wire logic [7:0]        host_rx_data_in,
	output logic                   host_tx_valid_out,
	output logic      [7:0]        host_tx_data_out,
	output logic                   screen_valid_out,
	output logic      [7:0]        screen_data_out
);

	// Offsets reach 0x10, so five address bits are the least that works
	if (ADDR_W < 5) begin : g_addr_check
		$error("ADDR_W too small for the register map");
	end

	// Everything the block remembers except the code character, registered as one word
	typedef struct packed {
		self_test_pkg::state_t state;
		self_test_pkg::test_t  test;
		logic                  chain;
		logic                  boot;
		logic                  evm_fitted;
		logic                  local_sel;
		logic                  local_forced;
		logic [3:0]            led;
		logic [3:0]            fatal_code;
		logic [4:0]            fault_mask;
		logic [2:0]            int_status;
		logic [2:0]            int_mask;
		logic [31:0]           prdata;
		logic                  pslverr;
		logic                  test_req;
		logic                  cursor_home;
		logic                  code_write;
		logic                  tx_valid;
		logic [7:0]            tx_data;
		logic                  scr_valid;
		logic [7:0]            scr_data;
	} core_t;

	core_t st_reg;
	core_t st_next;

	// One-hot fault bit for the test under way
	// Only the five listed tests exist; other codes give no bit
	function automatic logic [4:0] fault_bit(input self_test_pkg::test_t t);
		logic [4:0] b;
		b = 5'h00;
		unique case (t)
			self_test_pkg::TEST_EVM:   b = 5'h01;
			self_test_pkg::TEST_STORE: b = 5'h02;
			self_test_pkg::TEST_KBD:   b = 5'h04;
			self_test_pkg::TEST_LOOP:  b = 5'h08;
			self_test_pkg::TEST_MODEM: b = 5'h10;
			default:                   b = 5'h00;
		endcase
		return b;
	endfunction

	// Address match on the low register bits, upper bits must be zero
	function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
		return a == ADDR_W'(ofs);
	endfunction

	// Helper nets of the bus decode and the sequencer
	logic              setup_phase;
	logic              access_wr;
	logic              access_rd;
	logic              mapped;
	logic              powerup_trig;
	logic              line_mode;
	logic [31:0]       rd_word;
	logic [2:0]        int_set;

	// Zero-wait slave: data are prepared in the setup cycle
	assign setup_phase = psel_in && !penable_in;
	assign access_wr   = psel_in && penable_in && pwrite_in;
	assign access_rd   = psel_in && penable_in && !pwrite_in;
	assign mapped      = addr_is(paddr_in, self_test_pkg::OFS_CTRL)
		|| addr_is(paddr_in, self_test_pkg::OFS_STATUS)
		|| addr_is(paddr_in, self_test_pkg::OFS_INT_STATUS)
		|| addr_is(paddr_in, self_test_pkg::OFS_INT_MASK)
		|| addr_is(paddr_in, self_test_pkg::OFS_CODE);

	// Every restart source, including the boot after reset
	assign powerup_trig = st_reg.boot
		|| (setup_page_a_in && key_zero_in)
		|| proc_reset_in
		|| (access_wr && addr_is(paddr_in, self_test_pkg::OFS_CTRL)
			&& pwdata_in[self_test_pkg::CTRL_START]);

	// Read mux
	// Latched in the setup cycle, so a read never sees its own side effect
	always_comb begin
		rd_word = 32'h0000_0000;
		if (addr_is(paddr_in, self_test_pkg::OFS_CTRL)) begin
			rd_word[self_test_pkg::CTRL_EVM_FITTED] = st_reg.evm_fitted;
			rd_word[self_test_pkg::CTRL_LOCAL_SEL]  = st_reg.local_sel;
			rd_word[self_test_pkg::CTRL_LED_LSB +: 4] = st_reg.led;
		end else if (addr_is(paddr_in, self_test_pkg::OFS_STATUS)) begin
			rd_word[self_test_pkg::STAT_BUSY]   = st_reg.state != self_test_pkg::ST_IDLE
				&& st_reg.state != self_test_pkg::ST_HALT;
			rd_word[self_test_pkg::STAT_HALTED] = st_reg.state == self_test_pkg::ST_HALT;
			rd_word[self_test_pkg::STAT_LOCAL]  = st_reg.local_sel || st_reg.local_forced;
			rd_word[self_test_pkg::STAT_MASK_LSB +: 5]  = st_reg.fault_mask;
			rd_word[self_test_pkg::STAT_FATAL_LSB +: 4] = st_reg.fatal_code;
		end else if (addr_is(paddr_in, self_test_pkg::OFS_INT_STATUS)) begin
			rd_word[2:0] = st_reg.int_status;
		end else if (addr_is(paddr_in, self_test_pkg::OFS_INT_MASK)) begin
			rd_word[2:0] = st_reg.int_mask;
		end else if (addr_is(paddr_in, self_test_pkg::OFS_CODE)) begin
			rd_word[7:0] = code_char_out;
		end
	end

	// Whole next state of the block
	always_comb begin
		st_next             = st_reg;
		int_set             = 3'h0;
		st_next.test_req    = 1'b0;
		st_next.cursor_home = 1'b0;
		st_next.code_write  = 1'b0;
		st_next.tx_valid    = 1'b0;
		st_next.scr_valid   = 1'b0;
		st_next.boot        = 1'b0;

		// Bus setup cycle latches answer and error
		if (setup_phase) begin
			st_next.prdata  = rd_word;
			st_next.pslverr = !mapped;
		end

		// Register writes
		if (access_wr && addr_is(paddr_in, self_test_pkg::OFS_CTRL)) begin
			st_next.evm_fitted = pwdata_in[self_test_pkg::CTRL_EVM_FITTED];
			st_next.local_sel  = pwdata_in[self_test_pkg::CTRL_LOCAL_SEL];
			if (st_reg.state != self_test_pkg::ST_HALT) begin
				st_next.led = pwdata_in[self_test_pkg::CTRL_LED_LSB +: 4];
			end
			if (pwdata_in[self_test_pkg::CTRL_RESUME_LINE]) begin
				st_next.local_forced = 1'b0;
			end
		end
		if (access_wr && addr_is(paddr_in, self_test_pkg::OFS_INT_MASK)) begin
			st_next.int_mask = pwdata_in[2:0];
		end

		// Sequencer
		unique case (st_reg.state)
			self_test_pkg::ST_HALT: begin
				// Only a reset leaves the halt; every other event is ignored
				st_next.state = self_test_pkg::ST_HALT;
			end
			self_test_pkg::ST_IDLE: begin
				if (powerup_trig) begin
					st_next.state      = self_test_pkg::ST_ISSUE;
					st_next.chain      = 1'b1;
					st_next.fault_mask = 5'h00;
					st_next.local_forced = 1'b0;
					st_next.test       = st_next.evm_fitted ? self_test_pkg::TEST_EVM
						: self_test_pkg::TEST_STORE;
				end else if (proc_loopback_req_in) begin
					st_next.state = self_test_pkg::ST_ISSUE;
					st_next.chain = 1'b0;
					st_next.test  = self_test_pkg::TEST_LOOP;
				end else if (proc_modem_req_in) begin
					st_next.state = self_test_pkg::ST_ISSUE;
					st_next.chain = 1'b0;
					st_next.test  = self_test_pkg::TEST_MODEM;
				end
			end
			self_test_pkg::ST_ISSUE: begin
				st_next.test_req = 1'b1;
				st_next.state    = self_test_pkg::ST_WAIT;
			end
			self_test_pkg::ST_WAIT: begin
				if (test_done_in) begin
					if (test_fatal_in) begin
						// Freeze at once; LEDs carry the code as a best effort
						st_next.state      = self_test_pkg::ST_HALT;
						st_next.fatal_code = test_fatal_code_in;
						st_next.led        = test_fatal_code_in;
						int_set[self_test_pkg::INT_FATAL] = 1'b1;
					end else begin
						if (test_fault_in) begin
							st_next.fault_mask = st_reg.fault_mask | fault_bit(st_reg.test);
						end
						// Power-up chain stops after the keyboard test
						if (st_reg.chain && st_reg.test != self_test_pkg::TEST_KBD) begin
							st_next.state = self_test_pkg::ST_ISSUE;
							st_next.test  = st_reg.test == self_test_pkg::TEST_EVM
								? self_test_pkg::TEST_STORE : self_test_pkg::TEST_KBD;
						end else begin
							st_next.state = self_test_pkg::ST_REPORT;
						end
					end
				end
			end
			self_test_pkg::ST_REPORT: begin
				st_next.state = self_test_pkg::ST_IDLE;
				if (st_reg.fault_mask != 5'h00) begin
					st_next.local_forced = 1'b1;
					st_next.code_write   = 1'b1;
					int_set[self_test_pkg::INT_NONFATAL] = 1'b1;
				end else begin
					if (st_reg.chain) begin
						st_next.cursor_home = 1'b1;
						st_next.led         = self_test_pkg::RST_LED;
					end
					int_set[self_test_pkg::INT_PASS] = 1'b1;
				end
			end
			default: begin
				st_next.state = self_test_pkg::ST_IDLE;
			end
		endcase

		// A processor or operator restart aborts a test in progress.
		// A fatal result in the same cycle wins: the halt is never undone.
		// An issue cycle's request is dropped so the request pulses once.
		if (powerup_trig && st_reg.state != self_test_pkg::ST_IDLE
			&& st_reg.state != self_test_pkg::ST_HALT
			&& st_next.state != self_test_pkg::ST_HALT) begin
			st_next.state        = self_test_pkg::ST_ISSUE;
			st_next.test_req     = 1'b0;
			st_next.chain        = 1'b1;
			st_next.fault_mask   = 5'h00;
			st_next.local_forced = 1'b0;
			st_next.cursor_home  = 1'b0;
			st_next.code_write   = 1'b0;
			int_set              = 3'h0;
			st_next.test         = st_next.evm_fitted ? self_test_pkg::TEST_EVM
				: self_test_pkg::TEST_STORE;
		end

		// Read of interrupt status clears it; a same-cycle event survives
		if (access_rd && addr_is(paddr_in, self_test_pkg::OFS_INT_STATUS)) begin
			st_next.int_status = int_set;
		end else begin
			st_next.int_status = st_reg.int_status | int_set;
		end

		// Character paths, dead during tests and after a fatal halt
		// Nothing moves in the cycle the sequencer leaves or enters idle
		if (st_next.state == self_test_pkg::ST_IDLE && st_reg.state == self_test_pkg::ST_IDLE) begin
			if (!line_mode) begin
				st_next.scr_valid = key_valid_in;
				st_next.scr_data  = key_data_in;
			end else begin
				st_next.tx_valid  = key_valid_in;
				st_next.tx_data   = key_data_in;
				st_next.scr_valid = host_rx_valid_in;
				st_next.scr_data  = host_rx_data_in;
			end
		end
	end

	// Local when selected by software or forced by a nonfatal fault
	// Forced local stays until a resume write or a new power-up run
	assign line_mode = !(st_reg.local_sel || st_reg.local_forced);

	// Single state register
	// Boot flag makes the first cycle after reset act as a power-up event
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st_reg              <= '0;
			st_reg.state        <= self_test_pkg::ST_IDLE;
			st_reg.test         <= self_test_pkg::TEST_EVM;
			st_reg.boot         <= 1'b1;
			st_reg.evm_fitted   <= self_test_pkg::RST_EVM_FITTED;
			st_reg.int_mask     <= self_test_pkg::RST_INT_MASK;
			st_reg.led          <= self_test_pkg::RST_LED;
		end else begin
			st_reg <= st_next;
		end
	end

	// Code character built in step with the code write pulse
	fault_code_former #(
		.MASK_W (5)
	) u_code (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.load_in  (st_next.code_write),
		.mask_in  (st_reg.fault_mask),
		.char_out (code_char_out)
	);

	// Outputs
	// Ready is tied high: every access completes in its first access cycle
	assign pready_out        = 1'b1;
	assign prdata_out        = st_reg.prdata;
	assign pslverr_out       = st_reg.pslverr && psel_in && penable_in;
	assign irq_out           = |(st_reg.int_status & st_reg.int_mask);
	assign test_req_out      = st_reg.test_req;
	assign test_sel_out      = st_reg.test;
	assign cursor_home_out   = st_reg.cursor_home;
	assign code_write_out    = st_reg.code_write;
	assign fault_leds_out    = st_reg.led;
	assign halted_out        = st_reg.state == self_test_pkg::ST_HALT;
	assign local_mode_out    = !line_mode;
	assign host_tx_valid_out = st_reg.tx_valid;
	assign host_tx_data_out  = st_reg.tx_data;
	assign screen_valid_out  = st_reg.scr_valid;
	assign screen_data_out   = st_reg.scr_data;

endmodule

/* File: verification/test_engine_model.sv */
// Behavioural test engine answering the sequencer's test requests
`timescale 1ns/1ps
module test_engine_model (
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	input  wire logic       req_in,
	input  wire logic [2:0] sel_in,
	input  wire logic [4:0] fault_bits_in,
	input  wire logic       fatal_en_in,
	input  wire logic [2:0] fatal_at_in,
	input  wire logic [3:0] fatal_code_in,
	output logic            done_out,
	output logic            fault_out,
	output logic            fatal_out,
	output logic [3:0]      code_out
);
	logic       busy_reg;
	logic [2:0] sel_reg;
	int         wait_reg;
	// Answer after 0..3 idle cycles; result lines toggle when not valid
	always @(posedge clk_in) begin
		if (reset_in) begin
			busy_reg <= 1'b0;
			done_out <= 1'b0;
			fault_out <= 1'b0;
			fatal_out <= 1'b0;
			code_out <= 4'h0;
		end else begin
			done_out <= 1'b0;
			fault_out <= ~fault_out;
			fatal_out <= ~fatal_out;
			code_out <= ~code_out;
			if (req_in) begin
				busy_reg <= 1'b1;
				sel_reg <= sel_in;
				wait_reg <= $urandom % 4;
			end else if (busy_reg && wait_reg > 0) begin
				wait_reg <= wait_reg - 1;
			end else if (busy_reg) begin
				// One result per request, as the requested test dictates
				busy_reg <= 1'b0;
				done_out <= 1'b1;
				fault_out <= fault_bits_in[sel_reg];
				fatal_out <= fatal_en_in && (fatal_at_in == sel_reg);
				code_out <= fatal_code_in;
			end
		end
	end
endmodule

/* File: verification/self_test_asserts.sv */
// Port checker for the power-up self-test sequencer
`timescale 1ns/1ps
module self_test_asserts (
	input wire logic       clk_in,
	input wire logic       reset_in,
	input wire logic       setup_page_a_in,
	input wire logic       key_zero_in,
	input wire logic       proc_reset_in,
	input wire logic       test_req_out,
	input wire logic       test_done_in,
	input wire logic       test_fatal_in,
	input wire logic [3:0] test_fatal_code_in,
	input wire logic       cursor_home_out,
	input wire logic       code_write_out,
	input wire logic [7:0] code_char_out,
	input wire logic [3:0] fault_leds_out,
	input wire logic       halted_out,
	input wire logic       local_mode_out,
	input wire logic       host_tx_valid_out,
	input wire logic       screen_valid_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// Restart paths answer two edges later unless halted
	a_key_restart: assert property (setup_page_a_in && key_zero_in && !halted_out |-> ##2 test_req_out)
		else $error("zero key in set-up page did not start tests");
	a_proc_restart: assert property (proc_reset_in && !halted_out |-> ##2 test_req_out)
		else $error("processor reset did not start tests");
	a_req_pulse: assert property (test_req_out |=> !test_req_out)
		else $error("test request longer than one cycle");
	a_pass_leds: assert property (cursor_home_out |-> fault_leds_out == 4'h0 && !code_write_out)
		else $error("pass report with leds lit or code written");
	a_fatal_halt: assert property (test_done_in && test_fatal_in && !halted_out
		|=> halted_out && fault_leds_out == $past(test_fatal_code_in))
		else $error("fatal result not halted with code on leds");
	// A halt is final and silences every path
	a_halt_sticky: assert property (halted_out |=> halted_out && !test_req_out)
		else $error("halted block woke up");
	a_halt_quiet: assert property (halted_out |-> !screen_valid_out && !host_tx_valid_out)
		else $error("character moved while halted");
	a_code_local: assert property (code_write_out |-> local_mode_out
		&& code_char_out > 8'h30 && code_char_out < 8'h50)
		else $error("code write without local mode or with bad character");
	a_local_tx: assert property (local_mode_out && $past(local_mode_out) |-> !host_tx_valid_out)
		else $error("host transmit while local");
endmodule
bind powerup_self_test_reporter self_test_asserts chk (.clk_in, .reset_in, .setup_page_a_in,
	.key_zero_in, .proc_reset_in, .test_req_out, .test_done_in, .test_fatal_in,
	.test_fatal_code_in, .cursor_home_out, .code_write_out, .code_char_out, .fault_leds_out,
	.halted_out, .local_mode_out, .host_tx_valid_out, .screen_valid_out);

/* File: verification/tb_top.sv */
// Self-checking bench for the power-up self-test sequencer
`timescale 1ns/1ps
module tb_top;
	logic clk_in = 0, reset_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
	logic [7:0] paddr_in = 8'h00, key_data_in = 8'h00, host_rx_data_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0, prdata_out;
	logic pready_out, pslverr_out, irq_out, test_req_out, test_done_in, test_fault_in;
	logic setup_page_a_in = 0, key_zero_in = 0, proc_reset_in = 0;
	logic proc_loopback_req_in = 0, proc_modem_req_in = 0, test_fatal_in;
	logic key_valid_in = 0, host_rx_valid_in = 0, host_tx_valid_out, screen_valid_out;
	logic cursor_home_out, code_write_out, halted_out, local_mode_out;
	logic [2:0] test_sel_out;
	logic [3:0] test_fatal_code_in, fault_leds_out;
	logic [7:0] code_char_out, host_tx_data_out, screen_data_out;
	logic [4:0] fault_bits = 5'h0;
	logic fatal_en = 0, fit = 0, h, c, e;
	logic [3:0] fcode = 4'h0;
	logic [7:0] ch;
	logic [11:0] seqv = 12'h0;
	logic [31:0] r;
	int n_mismatch = 0, num_checks = 0;

	always #12.5 clk_in = ~clk_in;
	powerup_self_test_reporter dut (.clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in,
		.paddr_in, .pwdata_in, .pready_out, .prdata_out, .pslverr_out, .irq_out,
		.setup_page_a_in, .key_zero_in, .proc_reset_in, .proc_loopback_req_in,
		.proc_modem_req_in, .test_req_out, .test_sel_out, .test_done_in, .test_fault_in,
		.test_fatal_in, .test_fatal_code_in, .cursor_home_out, .code_write_out,
		.code_char_out, .fault_leds_out, .halted_out, .local_mode_out, .key_valid_in,
		.key_data_in, .host_rx_valid_in, .host_rx_data_in, .host_tx_valid_out,
		.host_tx_data_out, .screen_valid_out, .screen_data_out);
	test_engine_model engine (.clk_in(clk_in), .reset_in(reset_in), .req_in(test_req_out),
		.sel_in(test_sel_out), .fault_bits_in(fault_bits), .fatal_en_in(fatal_en),
		.fatal_at_in(3'h2), .fatal_code_in(fcode), .done_out(test_done_in),
		.fault_out(test_fault_in), .fatal_out(test_fatal_in), .code_out(test_fatal_code_in));

	// Record the order of requested tests
	always @(posedge clk_in) if (test_req_out === 1'b1) seqv <= {seqv[8:0], test_sel_out};

	function automatic logic [11:0] exp_seq(input logic f);
		return f ? {3'h7, 3'h0, 3'h1, 3'h2} : {3'h7, 3'h7, 3'h1, 3'h2};
	endfunction
	function automatic logic [7:0] exp_code(input logic [4:0] m);
		return 8'h30 + {3'h0, m};
	endfunction

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// One APB transfer; holds the request until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		{psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, w, a, d};
		@(posedge clk_in);
		penable_in <= 1'b1;
		do begin
			@(posedge clk_in);
		end while (pready_out !== 1'b1);
		r = prdata_out;
		e = pslverr_out;
		{psel_in, penable_in} <= 2'b00;
	endtask
	// Bounded wait for the report of a test run
	task automatic wait_report();
		int n;
		n = 0;
		h = 0;
		c = 0;
		while (n < 300 && !h && !c && halted_out !== 1'b1) begin
			@(negedge clk_in);
			h = cursor_home_out === 1'b1;
			c = code_write_out === 1'b1;
			ch = code_char_out;
			n++;
		end
		if (n >= 300) chk("report wait", 1, 0);
	endtask
	// Key and host strobes together; local echoes keys, line passes both ways
	task automatic path(input logic loc);
		logic [7:0] kd, rd;
		kd = 8'($urandom);
		rd = 8'($urandom);
		@(posedge clk_in);
		{key_valid_in, key_data_in, host_rx_valid_in, host_rx_data_in} <= {1'b1, kd, 1'b1, rd};
		@(posedge clk_in);
		{key_valid_in, host_rx_valid_in} <= 2'b00;
		@(negedge clk_in);
		chk("tx valid", !loc, host_tx_valid_out);
		chk("screen data", {1'b1, loc ? kd : rd}, {screen_valid_out, screen_data_out});
		if (!loc) chk("tx data", kd, host_tx_data_out);
	endtask
	// Restart by one of the four paths, then judge the report
	task automatic trial(input int how, input logic f, input logic [4:0] m);
		logic [4:0] x;
		fit = f;
		fault_bits = m;
		x = m & (f ? 5'h07 : 5'h06);
		seqv = 12'hfff;
		if (how != 3) apb(1, 8'h00, {31'h0, f} | (how == 0 ? 32'h54 : 32'h50));
		@(posedge clk_in);
		if (how == 1) proc_reset_in <= 1'b1;
		if (how == 2) {setup_page_a_in, key_zero_in} <= 2'b11;
		@(posedge clk_in);
		{proc_reset_in, setup_page_a_in, key_zero_in} <= 3'b000;
		wait_report();
		chk("test order", exp_seq(fit), seqv);
		chk("pass seen", x == 0 && !fatal_en, h);
		if (x == 0 && !fatal_en) chk("leds", 4'h0, fault_leds_out);
		if (x != 0) chk("code char", exp_code(x), {8{c}} & ch);
		chk("local", x != 0, local_mode_out);
		apb(0, 8'h04, 32'h0);
		chk("fault mask", x, r[12:8]);
		if (!fatal_en) path(x != 0);
		$display("trial by path %0d mask %h done", how, x);
	endtask

	initial begin
		#(25 * 40000);
		n_mismatch++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'hd859));
		repeat (12) @(posedge clk_in);
		reset_in <= 1'b0;
		trial(3, 0, 5'h00);
		// Interrupt raised by the pass, cleared by reading interrupt status
		apb(1, 8'h0c, 32'h1);
		@(negedge clk_in);
		chk("irq raised", 1, irq_out);
		apb(0, 8'h08, 32'h0);
		chk("int status", 3'h1, r[2:0]);
		@(negedge clk_in);
		chk("irq cleared", 0, irq_out);
		apb(0, 8'h20, 32'h0);
		chk("unmapped err", 1, e);
		chk("unmapped data", 0, r);
		$display("register test done");
		// Software local select echoes keys and cuts the host
		apb(1, 8'h00, 32'h2);
		path(1);
		trial(0, 1, 5'h05);
		// Resume write leaves forced local while the mask stays
		apb(1, 8'h00, 32'h9);
		path(0);
		// Separately requested tests add to the standing mask
		fault_bits = 5'h18;
		seqv = 12'hfff;
		@(posedge clk_in);
		proc_loopback_req_in <= 1'b1;
		@(posedge clk_in);
		proc_loopback_req_in <= 1'b0;
		wait_report();
		chk("loop code", 8'h3d, ch);
		@(posedge clk_in);
		proc_modem_req_in <= 1'b1;
		@(posedge clk_in);
		proc_modem_req_in <= 1'b0;
		wait_report();
		chk("modem code", 8'h4d, ch);
		chk("single tests", {6'h3f, 3'h3, 3'h4}, seqv);
		$display("single tests done");
		for (int i = 0; i < 9; i++) trial(i % 3, 1'($urandom), 5'($urandom));
		// Fatal result on the last test halts with code on the leds
		fatal_en = 1;
		fcode = 4'(1 + ($urandom % 15));
		trial(0, 0, 5'h00);
		chk("halted", 1, halted_out);
		chk("fatal leds", fcode, fault_leds_out);
		seqv = 12'hfff;
		@(posedge clk_in);
		proc_reset_in <= 1'b1;
		@(posedge clk_in);
		proc_reset_in <= 1'b0;
		repeat (10) @(posedge clk_in);
		chk("no restart", 12'hfff, seqv);
		$display("fatal test done");
		// Only a reset leaves the halt, and it runs the power-up tests again
		reset_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		fatal_en = 0;
		reset_in <= 1'b0;
		trial(3, 0, 5'h00);
		end_of_test();
	end
endmodule
